// *** rtl/asgo_pkg.sv ***
// Package: register map, field positions and reset values of the sync/gain/offset control block
package asgo_pkg;

	// ******************************************************************
	// Register offsets
	// ******************************************************************
	localparam logic [7:0] ADDR_INPUT_CONFIG  = 8'h05;
	localparam logic [7:0] ADDR_RED_GAIN      = 8'h06;
	localparam logic [7:0] ADDR_GREEN_GAIN    = 8'h07;
	localparam logic [7:0] ADDR_BLUE_GAIN     = 8'h08;
	localparam logic [7:0] ADDR_RED_OFFSET    = 8'h09;
	localparam logic [7:0] ADDR_GREEN_OFFSET  = 8'h0a;
	localparam logic [7:0] ADDR_BLUE_OFFSET   = 8'h0b;
	localparam logic [7:0] ADDR_OFFSET_FINE   = 8'h0c;
	localparam logic [7:0] ADDR_BW_PEAK       = 8'h0d;
	localparam logic [7:0] ADDR_CLAMP_SRC     = 8'h13;
	localparam logic [7:0] ADDR_BLACK_CFG     = 8'h17;
	localparam logic [7:0] ADDR_LOOP_GAIN     = 8'h1c;
	localparam logic [7:0] ADDR_STATUS        = 8'h30;

	// ******************************************************************
	// Field positions
	// ******************************************************************
	localparam int SEL_LSB          = 3;
	localparam int MASK_DIS_BIT     = 6;
	localparam int HOUT_MASK_DIS    = 7;
	localparam int RANGE_BIT        = 0;
	localparam int FINE_LSB         = 2;
	localparam int BW_LSB           = 1;
	localparam int PEAK_LSB         = 4;
	localparam int EXT_CLAMP_LSB    = 4;
	localparam int AUTO_OFF_BIT     = 0;

	// ******************************************************************
	// Reset values and the fast loop gain code
	// ******************************************************************
	localparam logic [7:0] RST_INPUT_CONFIG = 8'h00;
	localparam logic [7:0] RST_GAIN         = 8'h55;
	localparam logic [7:0] RST_OFFSET       = 8'h80;
	localparam logic [7:0] RST_OFFSET_FINE  = 8'h00;
	localparam logic [7:0] RST_BW_PEAK      = 8'h0e;
	localparam logic [7:0] RST_CLAMP_SRC    = 8'h00;
	localparam logic [7:0] RST_BLACK_CFG    = 8'h00;
	localparam logic [7:0] RST_LOOP_GAIN    = 8'h49;
	localparam logic [7:0] LOOP_GAIN_FAST   = 8'h4c;

	// ******************************************************************
	// Timing
	// ******************************************************************
	localparam longint CLK_HZ           = 40000000;
	localparam longint GAIN_TIMEOUT_MS  = 100;
	localparam longint GAIN_TIMEOUT_CYC = (GAIN_TIMEOUT_MS * CLK_HZ) / 1000;

	// Horizontal timing source
	typedef enum logic [1:0] {
		SRC_SEPARATE,
		SRC_COMPOSITE_SYNC_ON_HSYNC,
		SRC_SYNC_ON_GREEN
	} asgo_src_t;

	// Decode of the two-bit source select field
	function automatic asgo_src_t asgo_src_dec(input logic [1:0] f);
		unique case (f)
			2'h1:    asgo_src_dec = SRC_COMPOSITE_SYNC_ON_HSYNC;
			2'h2:    asgo_src_dec = SRC_SYNC_ON_GREEN;
			default: asgo_src_dec = SRC_SEPARATE;
		endcase
	endfunction : asgo_src_dec

endpackage : asgo_pkg

// *** rtl/asgo_sync_sync.sv ***
// Two-flop synchroniser for asynchronous level inputs
`timescale 1ns/10ps
module asgo_sync_sync
	import asgo_pkg::*;
#(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_rstn,
	// Data
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= i_async;
			sync_ff <= meta_ff;
		end
	end

	assign o_sync = sync_ff;

endmodule : asgo_sync_sync

// *** rtl/asgo_gain_lane.sv ***
// One channel's gain holding register, loaded on the line clamp strobe or on timeout
`timescale 1ns/10ps
module asgo_gain_lane
	import asgo_pkg::*;
(
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rstn,
	// Control
	input  wire logic       i_load,
	input  wire logic [7:0] i_code,
	// Amplifier side
	output logic      [7:0] o_gain
);

	logic [7:0] gain_ff;

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			gain_ff <= RST_GAIN;
		end else if (i_load) begin
			gain_ff <= i_code; // see R09
		end
	end

	assign o_gain = gain_ff;

endmodule : asgo_gain_lane

// *** rtl/asgo_ctrl.sv ***
// Top: sync masking, loop gain, channel gain update, bandwidth/peaking and offset control
//
// What this block does
// R01: Horizontal timing from separate syncs, composite on hsync, or composite on green.
// R02: Copy-protection mask is ANDed into green composite sync before the clock loop.
// R03: Input config bit 6 set disables the copy-protection masking.
// R04: With masking enabled, the mask is also applied to the hsync output.
// R05: Input config bit 7 set leaves the hsync output unmasked.
// R06: Loop gain value 0x4c gives full phase gain, low frequency gain.
// R07: Software should keep loop gain at default 0x49 except for tape sources.
// R08: Gain is one half plus code over 170; unity is code 0x55.
// R09: Written gain reaches the amplifier on the next per-line clamp strobe.
// R10: Without line strobes a gain write applies after at most 100 ms.
// R11: Bandwidth bits 3:1 select one of eight filter corners; bit 0 ignored.
// R12: Bandwidth bits 7:4 select peaking zero; zero disables peaking.
// R13: Software should treat peaking codes above 0x2 as advanced adjustments.
// R14: In automatic mode offset registers are a digital adder in one LSB steps.
// R15: In manual mode the 10-bit offset converter takes register bits directly.
// R16: Offset fine register bit 0 halves the offset converter swing in both modes.
// R17: In reduced range one converter step weighs one eighth of an LSB.
// R18: Automatic black level runs once per line after hsync trailing edge.
// R19: Without detected copy protection composite sync passes unchanged.
// R20: Every configuration register is eight bits and reads back as written.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/10ps
module asgo_ctrl
	import asgo_pkg::*;
#(
	parameter int GAIN_TIMEOUT = int'(GAIN_TIMEOUT_CYC)
) (
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rstn,
	// Register port
	input  wire logic [7:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	output logic      [7:0] o_rdata,
	// Sync inputs from pins
	input  wire logic       i_hsync,
	input  wire logic       i_vsync,
	input  wire logic       i_sync_on_green,
	input  wire logic       i_cp_detect,
	input  wire logic       i_cp_mask_n,
	input  wire logic       i_ext_clamp,
	// Sync outputs
	output logic            o_loop_sync,
	output logic            o_hsync,
	output logic            o_vsync,
	// Gain outputs to amplifiers
	output logic      [7:0] o_red_gain,
	output logic      [7:0] o_green_gain,
	output logic      [7:0] o_blue_gain,
	// Analog controls
	output logic      [7:0] o_loop_gain,
	output logic      [2:0] o_bw_sel,
	output logic      [3:0] o_peak_sel,
	output logic            o_offset_half_range,
	output logic            o_black_level_run,
	// Offset converter codes and digital adders
	output logic      [9:0] o_red_dac,
	output logic      [9:0] o_green_dac,
	output logic      [9:0] o_blue_dac,
	output logic      [7:0] o_red_adder,
	output logic      [7:0] o_green_adder,
	output logic      [7:0] o_blue_adder,
	output logic            o_auto_mode
);

	// ******************************************************************
	// Registers
	// ******************************************************************
	logic [7:0] input_configuration_ff;
	logic [7:0] gain_ff [3];
	logic [7:0] offset_ff [3];
	logic [7:0] offset_fine_and_range_ff;
	logic [7:0] bandwidth_and_peaking_ff;
	logic [7:0] clamp_source_select_ff;
	logic [7:0] black_level_config_ff;
	logic [7:0] clock_loop_gain_ff;
	logic [7:0] rdata_ff;
	logic [7:0] nxt_rdata;

	// Every register is a plain byte that reads back what was written
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			input_configuration_ff   <= RST_INPUT_CONFIG;
			offset_fine_and_range_ff <= RST_OFFSET_FINE;
			bandwidth_and_peaking_ff <= RST_BW_PEAK;
			clamp_source_select_ff   <= RST_CLAMP_SRC;
			black_level_config_ff    <= RST_BLACK_CFG;
			clock_loop_gain_ff       <= RST_LOOP_GAIN;
		end else if (i_wr) begin
			unique case (i_addr)
				ADDR_INPUT_CONFIG: input_configuration_ff   <= i_wdata; // see R20
				ADDR_OFFSET_FINE:  offset_fine_and_range_ff <= i_wdata;
				ADDR_BW_PEAK:      bandwidth_and_peaking_ff <= i_wdata;
				ADDR_CLAMP_SRC:    clamp_source_select_ff   <= i_wdata;
				ADDR_BLACK_CFG:    black_level_config_ff    <= i_wdata;
				ADDR_LOOP_GAIN:    clock_loop_gain_ff       <= i_wdata; // see R06
				default: ;
			endcase
		end
	end

	// Per-channel gain and offset bytes, red/green/blue in index order
	genvar ch;
	generate
		for (ch = 0; ch < 3; ch++) begin : g_chan
			always_ff @(posedge i_clk or negedge i_rstn) begin
				if (!i_rstn) begin
					gain_ff[ch]   <= RST_GAIN; // see R08
					offset_ff[ch] <= RST_OFFSET;
				end else if (i_wr) begin
					if (i_addr == ADDR_RED_GAIN + 8'(ch)) begin
						gain_ff[ch] <= i_wdata;
					end
					if (i_addr == ADDR_RED_OFFSET + 8'(ch)) begin
						offset_ff[ch] <= i_wdata;
					end
				end
			end
		end
	endgenerate

	// ******************************************************************
	// Read path
	// ******************************************************************
	logic [7:0] status_byte;

	always_comb begin
		nxt_rdata = 8'h00;
		unique case (i_addr)
			ADDR_INPUT_CONFIG: nxt_rdata = input_configuration_ff;
			ADDR_RED_GAIN:     nxt_rdata = gain_ff[0];
			ADDR_GREEN_GAIN:   nxt_rdata = gain_ff[1];
			ADDR_BLUE_GAIN:    nxt_rdata = gain_ff[2];
			ADDR_RED_OFFSET:   nxt_rdata = offset_ff[0];
			ADDR_GREEN_OFFSET: nxt_rdata = offset_ff[1];
			ADDR_BLUE_OFFSET:  nxt_rdata = offset_ff[2];
			ADDR_OFFSET_FINE:  nxt_rdata = offset_fine_and_range_ff;
			ADDR_BW_PEAK:      nxt_rdata = bandwidth_and_peaking_ff;
			ADDR_CLAMP_SRC:    nxt_rdata = clamp_source_select_ff;
			ADDR_BLACK_CFG:    nxt_rdata = black_level_config_ff;
			ADDR_LOOP_GAIN:    nxt_rdata = clock_loop_gain_ff;
			ADDR_STATUS:       nxt_rdata = status_byte;
			default:           nxt_rdata = 8'h00;
		endcase
	end

	// Unmapped reads and idle cycles return zero
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rdata_ff <= 8'h00;
		end else begin
			rdata_ff <= i_rd ? nxt_rdata : 8'h00;
		end
	end

	// ******************************************************************
	// Sync inputs
	// ******************************************************************
	logic [5:0] pins_s;

	asgo_sync_sync #(
		.WIDTH (6)
	) u_pin_sync (
		.i_clk   (i_clk),
		.i_rstn  (i_rstn),
		.i_async ({i_ext_clamp, i_cp_mask_n, i_cp_detect, i_sync_on_green, i_vsync, i_hsync}),
		.o_sync  (pins_s)
	);

	logic      hs_s;
	logic      vs_s;
	logic      sog_s;
	logic      cp_det_s;
	logic      cp_mask_n_s;
	logic      ext_clamp_s;
	asgo_src_t src;

	assign hs_s        = pins_s[0];
	assign vs_s        = pins_s[1];
	assign sog_s       = pins_s[2];
	assign cp_det_s    = pins_s[3];
	assign cp_mask_n_s = pins_s[4];
	assign ext_clamp_s = pins_s[5];
	assign src         = asgo_src_dec(input_configuration_ff[SEL_LSB +: 2]);

	// ******************************************************************
	// Copy-protection masking
	// ******************************************************************
	logic mask_active;
	logic raw_hsync;
	logic loop_sync;
	logic hout_sync;

	// Mask only bites when protection is seen; else sync passes untouched
	assign mask_active = cp_det_s & ~input_configuration_ff[MASK_DIS_BIT]; // see R03, R19

	always_comb begin
		unique case (src)
			SRC_COMPOSITE_SYNC_ON_HSYNC: raw_hsync = hs_s;
			SRC_SYNC_ON_GREEN:  raw_hsync = sog_s;
			default:            raw_hsync = hs_s;
		endcase
	end // see R01

	assign loop_sync = (src == SRC_SYNC_ON_GREEN && mask_active) ? (raw_hsync & cp_mask_n_s) : raw_hsync; // see R02
	assign hout_sync = (mask_active && !input_configuration_ff[HOUT_MASK_DIS]) ?
	                   (raw_hsync & cp_mask_n_s) : raw_hsync; // see R04, R05

	logic loop_sync_ff;
	logic hsync_ff;
	logic vsync_ff;

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			loop_sync_ff <= 1'b0;
			hsync_ff     <= 1'b0;
			vsync_ff     <= 1'b0;
		end else begin
			loop_sync_ff <= loop_sync;
			hsync_ff     <= hout_sync;
			vsync_ff     <= vs_s;
		end
	end

	// ******************************************************************
	// Line strobe and gain transfer
	// ******************************************************************
	logic        trail_edge;
	logic        use_ext_clamp;
	logic        ext_prev_ff;
	logic        line_strobe;
	logic [31:0] timeout_ff;
	logic        timeout_hit;
	logic        gain_load;

	// Trailing edge of active-high sync marks the line
	assign trail_edge    = hsync_ff & ~hout_sync;
	assign use_ext_clamp = |clamp_source_select_ff[EXT_CLAMP_LSB +: 2];
	assign line_strobe   = use_ext_clamp ? (ext_clamp_s & ~ext_prev_ff) : trail_edge;
	assign timeout_hit   = (timeout_ff == 32'(GAIN_TIMEOUT - 1));
	assign gain_load     = line_strobe | timeout_hit; // see R09, R10

	// Fallback load so a write applies even with no line strobes
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			timeout_ff  <= 32'h0000_0000;
			ext_prev_ff <= 1'b0;
		end else begin
			ext_prev_ff <= ext_clamp_s;
			timeout_ff  <= gain_load ? 32'h0000_0000 : timeout_ff + 32'h0000_0001; // see R10
		end
	end

	generate
		for (ch = 0; ch < 3; ch++) begin : g_gain
			logic [7:0] lane_gain;
			asgo_gain_lane u_lane (
				.i_clk  (i_clk),
				.i_rstn (i_rstn),
				.i_load (gain_load),
				.i_code (gain_ff[ch]),
				.o_gain (lane_gain)
			);
		end
	endgenerate

	// ******************************************************************
	// Offset control
	// ******************************************************************
	logic       auto_mode;
	logic [9:0] dac_ff [3];
	logic [7:0] adder_ff [3];
	logic       run_ff;
	logic       auto_ff;

	assign auto_mode = ~black_level_config_ff[AUTO_OFF_BIT]; // see R18

	// Run pulse per line; mode flag turns in the same cycle as dacs and adders
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			run_ff  <= 1'b0;
			auto_ff <= 1'b1;
		end else begin
			run_ff  <= auto_mode & trail_edge; // see R18
			auto_ff <= auto_mode;
		end
	end

	generate
		for (ch = 0; ch < 3; ch++) begin : g_off
			always_ff @(posedge i_clk or negedge i_rstn) begin
				if (!i_rstn) begin
					dac_ff[ch]   <= 10'h000;
					adder_ff[ch] <= RST_OFFSET;
				end else if (auto_mode) begin
					adder_ff[ch] <= offset_ff[ch]; // see R14
				end else begin
					adder_ff[ch] <= RST_OFFSET;
					// Fine bits take the top two of the fine field
					dac_ff[ch]   <= {offset_ff[ch], offset_fine_and_range_ff[7:6]}; // see R15
				end
			end
		end
	endgenerate

	// ******************************************************************
	// Status and outputs
	// ******************************************************************
	assign status_byte = {4'h0, mask_active, cp_det_s, auto_mode, src == SRC_SYNC_ON_GREEN};

	assign o_rdata             = rdata_ff;
	assign o_loop_sync         = loop_sync_ff;
	assign o_hsync             = hsync_ff;
	assign o_vsync             = vsync_ff;
	assign o_red_gain          = g_gain[0].lane_gain;
	assign o_green_gain        = g_gain[1].lane_gain;
	assign o_blue_gain         = g_gain[2].lane_gain;
	assign o_loop_gain         = clock_loop_gain_ff; // see R06
	assign o_bw_sel            = bandwidth_and_peaking_ff[BW_LSB +: 3]; // see R11
	assign o_peak_sel          = bandwidth_and_peaking_ff[PEAK_LSB +: 4]; // see R12
	assign o_offset_half_range = offset_fine_and_range_ff[RANGE_BIT]; // see R16, R17
	assign o_black_level_run   = run_ff;
	assign o_red_dac           = dac_ff[0];
	assign o_green_dac         = dac_ff[1];
	assign o_blue_dac          = dac_ff[2];
	assign o_red_adder         = adder_ff[0];
	assign o_green_adder       = adder_ff[1];
	assign o_blue_adder        = adder_ff[2];
	assign o_auto_mode         = auto_ff;

endmodule : asgo_ctrl

// *** verif/asgo_video_src.sv ***
// Behavioural video source driving the sync pins of the control block
`timescale 1ns/10ps
module asgo_video_src #(
	parameter int LINE = 40
) (
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_rstn,
	// Scenario controls
	input  wire logic i_lines_on,
	input  wire logic i_cp_on,
	input  wire logic i_det_on,
	// Pins toward the block
	output logic      o_hsync,
	output logic      o_vsync,
	output logic      o_sog,
	output logic      o_cp_detect,
	output logic      o_cp_mask_n,
	output logic      o_ext_clamp
);
	logic [5:0] pos_ff;
	logic [2:0] line_ff;
	logic       pulse;

	// Composite sync: line pulse plus an injected pseudo pulse mid-line
	assign pulse = (pos_ff < 6'h04) || (i_cp_on && (pos_ff == 6'h14 || pos_ff == 6'h15));

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			pos_ff      <= 6'h00;
			line_ff     <= 3'h0;
			o_hsync     <= 1'b0;
			o_vsync     <= 1'b0;
			o_sog       <= 1'b0;
			o_cp_detect <= 1'b0;
			o_cp_mask_n <= 1'b1;
			o_ext_clamp <= 1'b0;
		end else begin
			pos_ff      <= (int'(pos_ff) == LINE - 1) ? 6'h00 : pos_ff + 6'h01;
			line_ff     <= (int'(pos_ff) == LINE - 1) ? line_ff + 3'h1 : line_ff;
			// Idle lines stand low between frames
			o_hsync     <= i_lines_on && pulse;
			o_sog       <= i_lines_on && pulse;
			o_vsync     <= i_lines_on && line_ff == 3'h0;
			o_cp_detect <= i_cp_on && i_det_on;
			o_cp_mask_n <= !(i_lines_on && i_cp_on && pos_ff >= 6'h12 && pos_ff <= 6'h17);
			o_ext_clamp <= i_lines_on && (pos_ff == 6'h08 || pos_ff == 6'h09);
		end
	end
endmodule : asgo_video_src

// *** verif/asgo_ctrl_assertions.sv ***
// Concurrent checks on the ports of the sync, gain and offset control block
`timescale 1ns/10ps
module asgo_ctrl_assertions
	import asgo_pkg::*;
#(
	parameter int GAIN_TIMEOUT = 50
) (
	input wire logic       i_clk,
	input wire logic       i_rstn,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic       i_wr,
	input wire logic       i_rd,
	input wire logic       i_hsync,
	input wire logic       i_sync_on_green,
	input wire logic       i_cp_detect,
	input wire logic       i_cp_mask_n,
	input wire logic [7:0] o_rdata,
	input wire logic       o_loop_sync,
	input wire logic       o_hsync,
	input wire logic [7:0] o_red_gain,
	input wire logic [7:0] o_loop_gain,
	input wire logic [2:0] o_bw_sel,
	input wire logic [3:0] o_peak_sel,
	input wire logic       o_offset_half_range,
	input wire logic       o_black_level_run,
	input wire logic       o_auto_mode
);
	localparam int GAIN_LIM = GAIN_TIMEOUT + 8;
	logic [7:0] cfg_ff, red_wr_ff;
	logic [2:0] age_ff;
	logic       cfg_ok, src, green;

	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rstn);

	// Shadow of the input configuration; sync checks wait until it has settled
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			cfg_ff    <= RST_INPUT_CONFIG;
			red_wr_ff <= RST_GAIN;
			age_ff    <= 3'h0;
		end else begin
			if (i_wr && i_addr == ADDR_INPUT_CONFIG) begin
				cfg_ff <= i_wdata;
				age_ff <= 3'h0;
			end else if (age_ff != 3'h7) begin
				age_ff <= age_ff + 3'h1;
			end
			if (i_wr && i_addr == ADDR_RED_GAIN) begin
				red_wr_ff <= i_wdata;
			end
		end
	end

	assign cfg_ok = (age_ff > 3'h4);
	assign green  = (cfg_ff[4:3] == 2'h2);
	assign src    = green ? i_sync_on_green : i_hsync;

	a_rdata_quiet: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
		else $error("read data not zero outside read cycle");
	a_loop_gain_wr: assert property (i_wr && i_addr == ADDR_LOOP_GAIN |=> o_loop_gain == $past(i_wdata))
		else $error("loop gain not taken from write");
	a_bw_peak_wr: assert property (i_wr && i_addr == ADDR_BW_PEAK |=>
		o_bw_sel == $past(i_wdata[3:1]) && o_peak_sel == $past(i_wdata[7:4])) else $error("bandwidth fields wrong");
	a_half_range_wr: assert property (i_wr && i_addr == ADDR_OFFSET_FINE |=>
		o_offset_half_range == $past(i_wdata[0])) else $error("range bit wrong");
	a_auto_follow: assert property (i_wr && i_addr == ADDR_BLACK_CFG |-> ##2
		o_auto_mode == !$past(i_wdata[0], 2)) else $error("auto mode does not follow control bit");
	a_run_in_auto: assert property (o_black_level_run |-> (o_auto_mode || $past(o_auto_mode)) ##1 !o_black_level_run)
		else $error("black level run outside auto mode or too long");
	a_hsync_masked: assert property (cfg_ok && !cfg_ff[6] && !cfg_ff[7] && $past(i_cp_detect, 3) &&
		!$past(i_cp_mask_n, 3) |-> !o_hsync) else $error("pulse leaked to sync output");
	a_hsync_pass: assert property (cfg_ok && (cfg_ff[6] || cfg_ff[7] || !$past(i_cp_detect, 3)) |->
		o_hsync == $past(src, 3)) else $error("sync output differs from source");
	a_loop_masked: assert property (cfg_ok && green && !cfg_ff[6] && $past(i_cp_detect, 3) &&
		!$past(i_cp_mask_n, 3) |-> !o_loop_sync) else $error("pulse leaked to clock loop");
	a_loop_pass: assert property (cfg_ok && (cfg_ff[6] || !green || !$past(i_cp_detect, 3)) |->
		o_loop_sync == $past(src, 3)) else $error("loop sync differs from source");
	a_gain_applied: assert property (i_wr && i_addr == ADDR_RED_GAIN |-> ##[2:GAIN_LIM] o_red_gain == red_wr_ff)
		else $error("gain write never reached amplifier");

	c_masked: cover property (cfg_ok && !cfg_ff[6] && $past(i_cp_detect, 3) && !$past(i_cp_mask_n, 3) && $past(src, 3));
	c_manual: cover property ($fell(o_auto_mode));
	c_gain: cover property ($changed(o_red_gain));
endmodule : asgo_ctrl_assertions

bind asgo_ctrl asgo_ctrl_assertions #(.GAIN_TIMEOUT(GAIN_TIMEOUT)) u_asgo_ctrl_assertions (.i_clk, .i_rstn, .i_addr,
	.i_wdata, .i_wr, .i_rd, .i_hsync, .i_sync_on_green, .i_cp_detect, .i_cp_mask_n, .o_rdata, .o_loop_sync, .o_hsync,
	.o_red_gain, .o_loop_gain, .o_bw_sel, .o_peak_sel, .o_offset_half_range, .o_black_level_run, .o_auto_mode);

// *** verif/asgo_ctrl_test.sv ***
// Self-checking testbench of the sync, gain and offset control block
`timescale 1ns/10ps
module asgo_ctrl_test
	import asgo_pkg::*;
;
	localparam int GT = 200;
	typedef struct {logic [7:0] addr; logic [7:0] exp;} asgo_note_t;
	asgo_note_t  q[$];
	logic        i_clk = 1'b0, i_rstn = 1'b0, i_wr = 1'b0, i_rd = 1'b0, rd_d = 1'b0;
	logic [7:0]  i_addr = 8'h00, i_wdata = 8'h00;
	logic        lines_on = 1'b0, cp_on = 1'b0, det_on = 1'b0;
	logic        i_hsync, i_vsync, i_sync_on_green, i_cp_detect, i_cp_mask_n, i_ext_clamp;
	logic [7:0]  o_rdata, o_red_gain, o_green_gain, o_blue_gain, o_loop_gain, o_red_adder, o_green_adder, o_blue_adder;
	logic [9:0]  o_red_dac, o_green_dac, o_blue_dac;
	logic [2:0]  o_bw_sel;
	logic [3:0]  o_peak_sel;
	logic        o_loop_sync, o_hsync, o_vsync, o_offset_half_range, o_black_level_run, o_auto_mode;
	int          bad_count = 0, check_count = 0, cyc = 0, hs_cnt = 0, ls_cnt = 0, bl_cnt = 0;
	logic [7:0]  ra[12] = '{ADDR_INPUT_CONFIG, ADDR_RED_GAIN, ADDR_GREEN_GAIN, ADDR_BLUE_GAIN, ADDR_RED_OFFSET,
		ADDR_GREEN_OFFSET, ADDR_BLUE_OFFSET, ADDR_OFFSET_FINE, ADDR_BW_PEAK, ADDR_CLAMP_SRC, ADDR_BLACK_CFG, ADDR_LOOP_GAIN};
	logic [7:0]  rv[12] = '{RST_INPUT_CONFIG, RST_GAIN, RST_GAIN, RST_GAIN, RST_OFFSET, RST_OFFSET, RST_OFFSET,
		RST_OFFSET_FINE, RST_BW_PEAK, RST_CLAMP_SRC, RST_BLACK_CFG, RST_LOOP_GAIN};
	// Detect flag, then input configuration
	logic [8:0]  cs[6] = '{9'h100, 9'h110, 9'h150, 9'h190, 9'h108, 9'h010};

	asgo_ctrl #(.GAIN_TIMEOUT(GT)) u_asgo_ctrl (.i_clk, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_hsync,
		.i_vsync, .i_sync_on_green, .i_cp_detect, .i_cp_mask_n, .i_ext_clamp, .o_loop_sync, .o_hsync, .o_vsync,
		.o_red_gain, .o_green_gain, .o_blue_gain, .o_loop_gain, .o_bw_sel, .o_peak_sel, .o_offset_half_range,
		.o_black_level_run, .o_red_dac, .o_green_dac, .o_blue_dac, .o_red_adder, .o_green_adder, .o_blue_adder,
		.o_auto_mode);
	asgo_video_src u_asgo_video_src (.i_clk(i_clk), .i_rstn(i_rstn), .i_lines_on(lines_on), .i_cp_on(cp_on),
		.i_det_on(det_on), .o_hsync(i_hsync), .o_vsync(i_vsync), .o_sog(i_sync_on_green), .o_cp_detect(i_cp_detect),
		.o_cp_mask_n(i_cp_mask_n), .o_ext_clamp(i_ext_clamp));

	always #12.5 i_clk = ~i_clk;

	// ****************************************************************
	// Bus tasks, compares and watchers
	// ****************************************************************
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_addr  <= a;
		i_wdata <= d;
		i_wr    <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
		@(posedge i_clk);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		q.push_back('{a, e});
		i_addr <= a;
		i_rd   <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		@(posedge i_clk);
	endtask : rd

	task automatic chk_rd(input asgo_note_t n, input logic [7:0] g);
		check_count++;
		if (g !== n.exp) begin
			$display("unexpected read of 0x%h expected 0x%h seen 0x%h", n.addr, n.exp, g);
			bad_count++;
		end
	endtask : chk_rd

	task automatic cmp(input string s, input logic [9:0] e, input logic [9:0] g);
		check_count++;
		if (g !== e) begin
			$display("unexpected %s expected 0x%h seen 0x%h", s, e, g);
			bad_count++;
		end
	endtask : cmp

	// Aligns to the next i_hsync rising edge (line pulse or mid-line pseudo pulse) and counts ten whole lines
	task automatic window();
		repeat (40) @(posedge i_clk);
		@(posedge i_hsync);
		hs_cnt = 0;
		ls_cnt = 0;
		bl_cnt = 0;
		repeat (400) @(posedge i_clk);
	endtask : window

	task automatic results();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : results

	always @(posedge i_clk) rd_d <= i_rd;
	always @(negedge i_clk) begin
		if (rd_d && q.size() > 0) begin
			chk_rd(q.pop_front(), o_rdata);
		end
	end
	always @(posedge o_hsync) hs_cnt++;
	always @(posedge o_loop_sync) ls_cnt++;
	always @(posedge i_clk) begin
		if (o_black_level_run === 1'b1) begin
			bl_cnt++;
		end
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			results();
		end
	end

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		int          k, n, eh, el;
		logic [31:0] r;
		void'($urandom(32'he78f));
		repeat (10) @(posedge i_clk);
		i_rstn <= 1'b1;
		@(posedge i_clk);
		for (k = 0; k < 12; k++) rd(ra[k], rv[k]);
		rd(8'h3f, 8'h00);
		rd(ADDR_STATUS, 8'h02);
		cmp("red_gain", 10'(RST_GAIN), 10'(o_red_gain));
		cmp("loop_gain", 10'(RST_LOOP_GAIN), 10'(o_loop_gain));
		for (k = 0; k < 12; k++) begin
			r = $urandom;
			wr(ra[k], r[7:0]);
			rd(ra[k], r[7:0]);
		end
		wr(ADDR_INPUT_CONFIG, 8'h00);
		wr(ADDR_CLAMP_SRC, 8'h00);
		for (k = 0; k < 16; k++) begin
			wr(ADDR_BW_PEAK, {k[3:0], k[2:0], k[0]});
			cmp("bw_sel", 10'(k[2:0]), 10'(o_bw_sel));
			cmp("peak_sel", 10'(k[3:0]), 10'(o_peak_sel));
		end
		wr(ADDR_BW_PEAK, 8'h2e);
		wr(ADDR_LOOP_GAIN, LOOP_GAIN_FAST);
		cmp("loop_gain", 10'(LOOP_GAIN_FAST), 10'(o_loop_gain));
		r = $urandom;
		wr(ADDR_BLACK_CFG, 8'h00);
		wr(ADDR_RED_OFFSET, r[7:0]);
		wr(ADDR_GREEN_OFFSET, r[23:16]);
		wr(ADDR_BLUE_OFFSET, r[15:8]);
		wr(ADDR_OFFSET_FINE, r[31:24]);
		cmp("red_adder", 10'(r[7:0]), 10'(o_red_adder));
		cmp("green_adder", 10'(r[23:16]), 10'(o_green_adder));
		cmp("blue_adder", 10'(r[15:8]), 10'(o_blue_adder));
		cmp("half_range", 10'(r[24]), 10'(o_offset_half_range));
		wr(ADDR_BLACK_CFG, 8'h01);
		wr(ADDR_LOOP_GAIN, RST_LOOP_GAIN);
		cmp("auto_mode", 10'h000, 10'(o_auto_mode));
		cmp("red_dac", {r[7:0], r[31:30]}, o_red_dac);
		cmp("green_dac", {r[23:16], r[31:30]}, o_green_dac);
		cmp("blue_dac", {r[15:8], r[31:30]}, o_blue_dac);
		wr(ADDR_BLACK_CFG, 8'h00);
		lines_on <= 1'b1;
		repeat (80) @(posedge i_clk);
		r = $urandom;
		wr(ADDR_BLUE_GAIN, r[23:16]);
		wr(ADDR_RED_GAIN, r[7:0]);
		for (n = 0; n < 48 && (o_red_gain !== r[7:0] || o_blue_gain !== r[23:16]); n++) @(posedge i_clk);
		cmp("red_gain", 10'(r[7:0]), 10'(o_red_gain));
		cmp("blue_gain", 10'(r[23:16]), 10'(o_blue_gain));
		lines_on <= 1'b0;
		repeat (80) @(posedge i_clk);
		wr(ADDR_CLAMP_SRC, 8'h10);
		wr(ADDR_GREEN_GAIN, r[15:8]);
		for (n = 0; n < GT + 8 && o_green_gain !== r[15:8]; n++) @(posedge i_clk);
		cmp("green_gain", 10'(r[15:8]), 10'(o_green_gain));
		lines_on <= 1'b1;
		cp_on    <= 1'b1;
		for (k = 0; k < 6; k++) begin
			det_on <= cs[k][8];
			wr(ADDR_INPUT_CONFIG, cs[k][7:0]);
			window();
			eh = (!cs[k][8] || cs[k][6] || cs[k][7]) ? 20 : 10;
			el = (!cs[k][8] || cs[k][6] || cs[k][4:3] != 2'h2) ? 20 : 10;
			cmp("hsync_edges", 10'(eh), 10'(hs_cnt));
			cmp("loop_edges", 10'(el), 10'(ls_cnt));
		end
		cp_on <= 1'b0;
		wr(ADDR_INPUT_CONFIG, 8'h00);
		window();
		cmp("run_pulses", 10'h00a, 10'(bl_cnt));
		wr(ADDR_BLACK_CFG, 8'h01);
		window();
		cmp("run_pulses", 10'h000, 10'(bl_cnt));
		results();
	end
endmodule : asgo_ctrl_test
